// File: common/tlf_pkg.sv
`default_nettype none

package tlf_pkg;

  // Two-wire slave sequencer
  typedef enum logic [2:0] {
    TS_IDLE,
    TS_DEV,
    TS_RX,
    TS_ACK,
    TS_TX,
    TS_MACK
  } tlf_twi_state_t;

  // Whole state of the two-wire slave
  typedef struct packed {
    logic           scl_q;
    logic           sda_q;
    tlf_twi_state_t state;
    logic [3:0]     bitcnt;
    logic [7:0]     shreg;
    logic [7:0]     ptr;
    logic           first;
    logic           rw;
    logic           sda_oe;
    logic           we;
    logic [7:0]     wdata;
  } tlf_twi_st_t;

  // Whole state of the laser and fault control
  typedef struct packed {
    logic [1:0] dis_s;
    logic [1:0] lf_s;
    logic [1:0] eye_s;
    logic [1:0] lv_s;
    logic [1:0] los_s;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       dis_q;
    logic       fault_latch;
    logic       soft_dis;
    logic       fault;
    logic       laser_off;
  } tlf_ctl_st_t;

endpackage

`default_nettype wire

// File: common/tlf_regs.svh
`ifndef TLF_REGS_SVH
`define TLF_REGS_SVH

// Two-wire address of the diagnostic page, 7-bit form (0xA2 on the wire)
`define TLF_DIAG_DEV_ADDR       7'h51

// Transmit control and status byte
`define TLF_TX_CTRL_STATUS_OFS  8'h6E
`define TLF_TX_CTRL_STATUS_RST  8'h00

// Field positions inside the control and status byte
`define TLF_BIT_DIS_STATE       7
`define TLF_BIT_SOFT_DIS        6
`define TLF_BIT_TX_FAULT        2
`define TLF_BIT_RX_SIGNAL_LOST          1

`endif

// File: hw/tlf_laser_fault_ctl.sv
// Overview of operation
// RULE_01: Laser off while disable pin is high.
// RULE_02: Laser off is pin OR software bit.
// RULE_03: Disable pin state readable at bit 7.
// RULE_04: Laser fault or low supply: flag, laser off.
// RULE_05: Fault pin open collector, high means fault.
// RULE_06: Laser fault stays latched after cause ends.
// RULE_07: Latch cleared by disable toggle or power-up.
// RULE_08: Low supply fault follows supply, never latched.
// RULE_09: Fault condition readable at bit 2.
// RULE_10: Eye-safety overrun counts as laser fault.
// RULE_11: Disable toggle during fault restarts transmitter.
// RULE_12: Signal-lost output, mirrored at bit 1.
// RULE_13: Diagnostic byte on two-wire bus, address 0xA2.
// RULE_14: Synchronise pin; toggle is completed high pulse.
`timescale 1ns/1ps
`default_nettype none
`include "tlf_regs.svh"

module tlf_laser_fault_ctl #(
  parameter logic [6:0] DEV_ADDR = `TLF_DIAG_DEV_ADDR
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic tx_disable_pin,
  input  wire logic laser_fault,
  input  wire logic eye_limit_exceeded,
  input  wire logic supply_low,
  input  wire logic rx_signal_lost_detect,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      tx_fault_out,
  output logic      tx_fault_oe,
  output logic      laser_off,
  output logic      rx_signal_lost
);
  import tlf_pkg::*;

  logic [1:0]  rst_pipe;
  logic        rst_n;
  tlf_ctl_st_t s;
  tlf_ctl_st_t next_s;
  logic        fault_cause;
  logic        dis_toggle;
  logic        reg_we;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;

  // Control and status byte as seen by the two-wire bus; all other bytes read zero
  function automatic logic [7:0] read_byte(input logic [7:0] a, input tlf_ctl_st_t st);
    logic [7:0] v;
    v = 8'h00;
    if (a == `TLF_TX_CTRL_STATUS_OFS) begin
      v[`TLF_BIT_DIS_STATE] = st.dis_s[1];  // RULE_03
      v[`TLF_BIT_SOFT_DIS]  = st.soft_dis;
      v[`TLF_BIT_TX_FAULT]  = st.fault;     // RULE_09
      v[`TLF_BIT_RX_SIGNAL_LOST]    = st.los_s[1];  // RULE_12
    end
    return v;
  endfunction

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Two-wire slave sees only synchronised levels
  tlf_twi_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_twi (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .scl    (s.scl_s[1]),
    .sda    (s.sda_s[1]),
    .rdata  (reg_rdata),
    .sda_oe (sda_oe),
    .addr   (reg_addr),
    .wdata  (reg_wdata),
    .we     (reg_we)
  ); // RULE_13

  assign reg_rdata = read_byte(reg_addr, s);

  // Fault causes and the disable toggle, from second sync stages only
  assign fault_cause = s.lf_s[1] | s.eye_s[1];  // RULE_10
  assign dis_toggle  = s.dis_q & ~s.dis_s[1];   // RULE_14

  // Next state of the control logic
  always_comb begin
    next_s       = s;
    // Pin inputs, two stages each; stage 0 feeds stage 1 only
    next_s.dis_s = {s.dis_s[0], tx_disable_pin};    // RULE_14
    next_s.lf_s  = {s.lf_s[0], laser_fault};
    next_s.eye_s = {s.eye_s[0], eye_limit_exceeded};
    next_s.lv_s  = {s.lv_s[0], supply_low};
    next_s.los_s = {s.los_s[0], rx_signal_lost_detect};
    next_s.scl_s = {s.scl_s[0], scl_in};
    next_s.sda_s = {s.sda_s[0], sda_in};
    next_s.dis_q = s.dis_s[1];
    // A live cause wins over a toggle, so a persistent fault cannot be cleared
    if (fault_cause) begin
      next_s.fault_latch = 1'b1;               // RULE_06
    end else if (dis_toggle) begin
      next_s.fault_latch = 1'b0;               // RULE_07 RULE_11
    end
    if (reg_we && reg_addr == `TLF_TX_CTRL_STATUS_OFS) begin
      next_s.soft_dis = reg_wdata[`TLF_BIT_SOFT_DIS];
    end
    // Low supply joins the flag unlatched
    next_s.fault     = next_s.fault_latch | s.lv_s[1];                // RULE_04 RULE_08
    next_s.laser_off = s.dis_s[1] | next_s.soft_dis | next_s.fault;   // RULE_02
  end

  // State register; laser held off while in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{dis_s: 2'b00, lf_s: 2'b00, eye_s: 2'b00, lv_s: 2'b00,
             los_s: 2'b00, scl_s: 2'b11, sda_s: 2'b11, dis_q: 1'b0,
             fault_latch: 1'b0,
             soft_dis: 1'(`TLF_TX_CTRL_STATUS_RST >> `TLF_BIT_SOFT_DIS),
             fault: 1'b0, laser_off: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // Open collector: pull low while healthy, release to show a fault
  assign tx_fault_out   = 1'b0;
  assign tx_fault_oe    = ~s.fault;  // RULE_05
  assign laser_off      = s.laser_off;  // RULE_01
  assign rx_signal_lost = s.los_s[1];   // RULE_12
  assign sda_out        = 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Completed high pulse on the synchronised disable pin
  sequence dis_pulse_s;
    s.dis_s[1] ##1 !s.dis_s[1];
  endsequence

  sequence quiet_s;
    !fault_cause && !s.lv_s[1] && !s.soft_dis && !s.dis_s[1];
  endsequence

  pin_disable_a: assert property ( // RULE_01
    s.dis_s[1] |=> laser_off)
    else $error("laser on while disable pin high");

  disable_or_a: assert property ( // RULE_02
    $past(rst_n) |-> laser_off == ($past(s.dis_s[1]) | s.soft_dis | s.fault))
    else $error("laser control is not pin OR bit OR fault");

  soft_write_a: assert property ( // RULE_02
    (reg_we && reg_addr == `TLF_TX_CTRL_STATUS_OFS)
    |=> s.soft_dis == $past(reg_wdata[`TLF_BIT_SOFT_DIS]) ##1 laser_off || !s.soft_dis)
    else $error("software disable not taken");

  fault_set_a: assert property ( // RULE_04
    fault_cause |=> (s.fault_latch && !tx_fault_oe && laser_off))
    else $error("laser fault not flagged");

  fault_hold_a: assert property ( // RULE_06
    (s.fault_latch && !fault_cause && !dis_toggle) |=> s.fault && !tx_fault_oe)
    else $error("laser fault latch lost");

  toggle_clear_a: assert property ( // RULE_07
    (dis_pulse_s ##0 quiet_s) |=> (!s.fault_latch && tx_fault_oe && !laser_off))
    else $error("disable toggle did not restart transmitter");

  supply_follow_a: assert property ( // RULE_08
    (!s.fault_latch && !fault_cause) |=> s.fault == $past(s.lv_s[1]))
    else $error("low supply fault latched or missed");

  status_mirror_a: assert property ( // RULE_09
    (reg_addr == `TLF_TX_CTRL_STATUS_OFS)
    |-> (reg_rdata[`TLF_BIT_TX_FAULT] == ~tx_fault_oe
         && reg_rdata[`TLF_BIT_DIS_STATE] == s.dis_s[1]
         && reg_rdata[`TLF_BIT_RX_SIGNAL_LOST] == rx_signal_lost))
    else $error("status byte does not mirror pins");

  eye_fault_a: assert property ( // RULE_10
    s.eye_s[1] |=> s.fault_latch [*1] ##1 s.fault)
    else $error("eye-safety overrun not latched");

  // Latch only drops on a completed disable pulse with no live cause
  latch_clear_only_a: assert property ( // RULE_07
    $fell(s.fault_latch) |-> ($past(dis_toggle) && !$past(fault_cause)))
    else $error("fault latch cleared without toggle");

  // Low supply alone must never leave the latch set
  supply_no_latch_a: assert property ( // RULE_08
    (s.lv_s[1] && !fault_cause && !s.fault_latch) |=> !s.fault_latch)
    else $error("low supply set the fault latch");

  los_follow_a: assert property ( // RULE_12
    $past(rst_n) |-> rx_signal_lost == $past(s.los_s[0]))
    else $error("signal-lost output does not follow input");

endmodule

`default_nettype wire

// File: hw/tlf_twi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlf_regs.svh"

module tlf_twi_slave #(
  parameter logic [6:0] DEV_ADDR = `TLF_DIAG_DEV_ADDR
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rdata,
  output logic            sda_oe,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  output logic            we
);
  import tlf_pkg::*;

  tlf_twi_st_t s;
  tlf_twi_st_t next_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;

  // Bus events from already synchronised levels
  assign scl_rise   = scl & ~s.scl_q;
  assign scl_fall   = ~scl & s.scl_q;
  assign start_cond = scl & s.scl_q & s.sda_q & ~sda;
  assign stop_cond  = scl & s.scl_q & ~s.sda_q & sda;

  // Byte sequencer; sda only changes after scl has fallen
  always_comb begin
    next_s       = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    next_s.we    = 1'b0;
    // Write address advances one cycle after the strobe, so addr is stable under it
    if (s.we) begin
      next_s.ptr = s.ptr + 8'h01;
    end
    if (stop_cond) begin
      next_s.state  = TS_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (start_cond) begin
      next_s.state  = TS_DEV;
      next_s.bitcnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.state)
        TS_DEV, TS_RX: begin
          if (scl_rise) begin
            next_s.shreg  = {s.shreg[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            next_s.sda_oe = 1'b1;
            next_s.state  = TS_ACK;
            if (s.state == TS_DEV) begin
              next_s.rw    = s.shreg[0];
              next_s.first = ~s.shreg[0];
              // Other addresses belong to other devices: stay silent
              if (s.shreg[7:1] != DEV_ADDR) begin
                next_s.sda_oe = 1'b0;
                next_s.state  = TS_IDLE;
              end
            end else if (s.first) begin
              next_s.ptr   = s.shreg;
              next_s.first = 1'b0;
            end else begin
              next_s.we    = 1'b1;
              next_s.wdata = s.shreg;
            end
          end
        end
        TS_ACK: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw) begin
              next_s.state  = TS_TX;
              next_s.shreg  = rdata;
              next_s.sda_oe = ~rdata[7];
            end else begin
              next_s.state  = TS_RX;
              next_s.sda_oe = 1'b0;
            end
          end
        end
        TS_TX: begin
          if (scl_fall) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'h7) begin
              next_s.state  = TS_MACK;
              next_s.sda_oe = 1'b0;
              next_s.ptr    = s.ptr + 8'h01;
            end else begin
              next_s.shreg  = {s.shreg[6:0], 1'b0};
              next_s.sda_oe = ~s.shreg[6];
            end
          end
        end
        TS_MACK: begin
          // rw doubles as the master's ack: a nack ends the read
          if (scl_rise) begin
            next_s.rw = ~sda;
          end else if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw) begin
              next_s.state  = TS_TX;
              next_s.shreg  = rdata;
              next_s.sda_oe = ~rdata[7];
            end else begin
              next_s.state = TS_IDLE;
            end
          end
        end
        default: begin
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{scl_q: 1'b1, sda_q: 1'b1, state: TS_IDLE, bitcnt: 4'h0,
             shreg: 8'h00, ptr: 8'h00, first: 1'b0, rw: 1'b0,
             sda_oe: 1'b0, we: 1'b0, wdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  assign sda_oe = s.sda_oe;
  assign addr   = s.ptr;
  assign wdata  = s.wdata;
  assign we     = s.we;

  // Own address is acknowledged on the falling edge that ends the byte
  dev_addr_ack_a: assert property ( // RULE_13
    @(posedge clk) disable iff (!rst_n)
    (s.state == TS_DEV && scl_fall && s.bitcnt == 4'h8 && !start_cond && !stop_cond
     && s.shreg[7:1] == DEV_ADDR) |=> (s.sda_oe && s.state == TS_ACK))
    else $error("own address not acknowledged");

  dev_addr_ignore_a: assert property ( // RULE_13
    @(posedge clk) disable iff (!rst_n)
    (s.state == TS_DEV && s.shreg[7:1] != DEV_ADDR) |=> !s.sda_oe)
    else $error("foreign address acknowledged");

endmodule

`default_nettype wire

// File: verification/tb_transceiver_laser_fault_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlf_regs.svh"

module tb_transceiver_laser_fault_control;
  logic sys_clk;
  logic resetn;
  logic laser_fault;
  logic eye;
  logic supply_low;
  logic los;
  logic sda_out, sda_oe, tx_fault_out, tx_fault_oe, laser_off, rx_signal_lost;
  logic scl, sda_lo, dis_pin;
  wire  sda_wire;
  wire  fault_pin;
  int   err_total = 0;
  int   num_checks = 0;
  int   cycles = 0;

  // Both pins have pull-ups on the host board
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_lo;
  assign fault_pin = tx_fault_oe ? tx_fault_out : 1'b1;

  always #5 sys_clk = ~sys_clk;

  tlf_laser_fault_ctl dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .tx_disable_pin(dis_pin),
    .laser_fault(laser_fault), .eye_limit_exceeded(eye), .supply_low(supply_low),
    .rx_signal_lost_detect(los), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .tx_fault_out(tx_fault_out), .tx_fault_oe(tx_fault_oe),
    .laser_off(laser_off), .rx_signal_lost(rx_signal_lost));

  tlf_host_model host_u (
    .clk(sys_clk), .sda(sda_wire), .scl(scl), .sda_lo(sda_lo), .dis_pin(dis_pin));

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %0b seen %0b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %2h seen %2h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic ok;
    host_u.reg_write(p, v, ok);
    chk1("write ack", 1'b1, ok);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] e, input string nm);
    logic [7:0] v;
    logic       ok;
    host_u.reg_read(p, v, ok);
    chk1("read ack", 1'b1, ok);
    chk8(nm, e, v);
  endtask

  task automatic t_reset();
    chk1("laser off in reset", 1'b1, laser_off);
    chk1("fault pin in reset", 1'b0, fault_pin);
    resetn = 1'b1;
    host_u.w(8);
    chk1("laser on after reset", 1'b0, laser_off);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h00, "status reset");
    rd(8'h6D, 8'h00, "other byte");
  endtask

  task automatic t_pin();
    host_u.set_dis(1'b1);
    chk1("pin laser off", 1'b1, laser_off);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h80, "pin state bit");
    host_u.set_dis(1'b0);
    chk1("pin laser on", 1'b0, laser_off);
  endtask

  // Only the soft bit is writable; it ORs with the pin
  task automatic t_soft();
    wr(`TLF_TX_CTRL_STATUS_OFS, 8'hFF);
    host_u.w(3);
    chk1("soft laser off", 1'b1, laser_off);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h40, "soft bit");
    wr(`TLF_TX_CTRL_STATUS_OFS, 8'hBF);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h00, "soft cleared");
    chk1("soft laser on", 1'b0, laser_off);
  endtask

  task automatic set_cause(input logic sel, input logic v);
    if (sel) begin
      eye = v;
    end else begin
      laser_fault = v;
    end
    host_u.w(5);
  endtask

  // Latched fault; a toggle while the cause persists must not clear it
  task automatic t_latch(input logic sel);
    set_cause(sel, 1'b1);
    chk1("fault pin set", 1'b1, fault_pin);
    chk1("fault laser off", 1'b1, laser_off);
    set_cause(sel, 1'b0);
    host_u.w(20);
    chk1("fault held", 1'b1, fault_pin);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h04, "fault bit");
    set_cause(sel, 1'b1);
    host_u.toggle();
    set_cause(sel, 1'b0);
    chk1("toggle under cause", 1'b1, fault_pin);
    host_u.toggle();
    chk1("fault cleared", 1'b0, fault_pin);
    chk1("laser resumed", 1'b0, laser_off);
  endtask

  task automatic t_supply();
    supply_low = 1'b1;
    host_u.w(5);
    chk1("supply fault", 1'b1, fault_pin);
    chk1("supply laser off", 1'b1, laser_off);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h04, "supply bit");
    supply_low = 1'b0;
    host_u.w(5);
    chk1("supply recovered", 1'b0, fault_pin);
    chk1("supply laser on", 1'b0, laser_off);
  endtask

  task automatic t_los();
    logic ok;
    los = 1'b1;
    host_u.w(4);
    chk1("signal lost", 1'b1, rx_signal_lost);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h02, "lost bit");
    los = 1'b0;
    host_u.w(4);
    chk1("signal back", 1'b0, rx_signal_lost);
    host_u.probe(8'hA0, ok);
    chk1("foreign address", 1'b0, ok);
  endtask

  // Neighbour byte ignores writes; the pointer then moves on to the control byte
  task automatic t_incr();
    logic ok;
    host_u.reg_write2(8'h6D, 8'h40, 8'h40, ok);
    chk1("burst ack", 1'b1, ok);
    rd(8'h6D, 8'h00, "dropped byte");
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h40, "second byte");
    chk1("burst laser off", 1'b1, laser_off);
    wr(`TLF_TX_CTRL_STATUS_OFS, 8'h00);
    chk1("burst laser on", 1'b0, laser_off);
  endtask

  // Power cycle also clears a latched laser fault
  task automatic t_power();
    set_cause(1'b0, 1'b1);
    set_cause(1'b0, 1'b0);
    chk1("fault before cycle", 1'b1, fault_pin);
    resetn = 1'b0;
    host_u.w(8);
    chk1("laser off in cycle", 1'b1, laser_off);
    resetn = 1'b1;
    host_u.w(8);
    chk1("fault after cycle", 1'b0, fault_pin);
    chk1("laser after cycle", 1'b0, laser_off);
    rd(`TLF_TX_CTRL_STATUS_OFS, 8'h00, "status after cycle");
  endtask

  // Reset held for 8 cycles, then scenarios in turn
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    laser_fault = 1'b0;
    eye = 1'b0;
    supply_low = 1'b0;
    los = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    t_reset();
    t_pin();
    t_soft();
    t_latch(1'b0);
    t_latch(1'b1);
    t_supply();
    t_los();
    t_incr();
    t_power();
    final_report();
  end
endmodule

`default_nettype wire

// File: verification/tlf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlf_regs.svh"

// Host board: laser-off pin driver and two-wire bus master
module tlf_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_lo,
  output logic      dis_pin
);
  // Bus idles released, clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
    dis_pin = 1'b0;
  end

  // Wait n edges, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Pin level held long enough to cross the two sync flops
  task automatic set_dis(input logic v);
    dis_pin = v;
    w(6);
  endtask

  // Completed high pulse clears a latched laser fault once no fault cause is live
  task automatic toggle();
    set_dis(1'b1);
    set_dis(1'b0);
  endtask

  // One bit; SDA moves only while SCL is low, sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    w(5);
    sda_lo = ~b;
    w(5);
    scl = 1'b1;
    w(4);
    got = sda;
    w(4);
    scl = 1'b0;
  endtask

  // Start, or repeated start when rep is set
  task automatic start(input logic rep);
    if (rep) begin
      w(5);
      sda_lo = 1'b0;
      w(5);
      scl = 1'b1;
      w(8);
    end
    sda_lo = 1'b1;
    w(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    w(5);
    sda_lo = 1'b1;
    w(5);
    scl = 1'b1;
    w(8);
    sda_lo = 1'b0;
    w(8);
  endtask

  // Byte MSB first plus ninth bit; nine=1 releases SDA for the answer
  task automatic xfer(input logic [7:0] b, input logic nine, output logic [7:0] got,
                      output logic lvl);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], t);
      got[i] = t;
    end
    bit_io(nine, lvl);
  endtask

  // Address byte only; ok is high when the device acknowledged
  task automatic probe(input logic [7:0] a, output logic ok);
    logic [7:0] d;
    logic       l;
    start(1'b0);
    xfer(a, 1'b1, d, l);
    stop();
    ok = ~l;
  endtask

  task automatic reg_write(input logic [7:0] p, input logic [7:0] v, output logic ok);
    logic [7:0] d;
    logic       l0, l1, l2;
    start(1'b0);
    xfer({`TLF_DIAG_DEV_ADDR, 1'b0}, 1'b1, d, l0);
    xfer(p, 1'b1, d, l1);
    xfer(v, 1'b1, d, l2);
    stop();
    ok = ~(l0 | l1 | l2);
  endtask

  // Two data bytes in one frame; the second lands at the next byte
  task automatic reg_write2(input logic [7:0] p, input logic [7:0] v0,
                            input logic [7:0] v1, output logic ok);
    logic [7:0] d;
    logic       l0, l1, l2, l3;
    start(1'b0);
    xfer({`TLF_DIAG_DEV_ADDR, 1'b0}, 1'b1, d, l0);
    xfer(p, 1'b1, d, l1);
    xfer(v0, 1'b1, d, l2);
    xfer(v1, 1'b1, d, l3);
    stop();
    ok = ~(l0 | l1 | l2 | l3);
  endtask

  // Pointer set, repeated start, one byte read, master NACK
  task automatic reg_read(input logic [7:0] p, output logic [7:0] v, output logic ok);
    logic [7:0] d;
    logic       l0, l1, l2, n;
    start(1'b0);
    xfer({`TLF_DIAG_DEV_ADDR, 1'b0}, 1'b1, d, l0);
    xfer(p, 1'b1, d, l1);
    start(1'b1);
    xfer({`TLF_DIAG_DEV_ADDR, 1'b1}, 1'b1, d, l2);
    xfer(8'hFF, 1'b1, v, n);
    stop();
    ok = ~(l0 | l1 | l2);
  endtask
endmodule

`default_nettype wire
